/* rtl/vtwf_pkg.sv */
/*
  Package for the tag identifier and wake pattern window block:
  register offsets, reset values, frame length limits, carrier structs.
  Assumes a 32-bit classic Wishbone register bus with byte addresses.
*/
package vtwf_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int          ADDR_W            = 12;
  localparam logic [11:0] OFF_FIRST_TAG     = 12'h120;
  localparam logic [11:0] OFF_SECOND_TAG    = 12'h124;
  localparam logic [11:0] OFF_PATTERN_WIN   = 12'h128;
  localparam logic [11:0] OFF_WAKE_CTRL     = 12'h12c;
  localparam int          PTR_CLEAR_BIT     = 31;
  localparam logic [15:0] TAG_RESET         = 16'hffff;
  localparam logic [31:0] PATTERN_RESET     = 32'h0000_0000;
  localparam logic [31:0] UNMAPPED_READ     = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Pattern store geometry and frame lengths
  // ----------------------------------------------------------------
  localparam int          PATTERN_DEPTH     = 40;
  localparam int          FILTER_COUNT      = 8;
  localparam int          PTR_W             = 6;
  localparam logic [10:0] MAX_LEN_PLAIN     = 11'd1518;
  localparam logic [10:0] MAX_LEN_TAGGED    = 11'd1522;
  localparam logic [10:0] TAG_BYTE_HI       = 11'd12;  // 13th byte, zero based
  localparam logic [10:0] TAG_BYTE_LO       = 11'd13;  // 14th byte, zero based

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       valid;
    logic       sof;
    logic       eof;
    logic [7:0] data;
  } vtwf_rx_byte_t;

  typedef struct packed {
    logic done;
    logic tag1;
    logic tag2;
    logic too_long;
  } vtwf_rx_status_t;

endpackage

/* rtl/vtwf_tag_detect.sv */
/*
  Receive-side tag detector and frame length judge.
  Assumes one byte per valid cycle, sof on the first and eof on the last.
*/
`timescale 1ns/1ns
`default_nettype none
module vtwf_tag_detect (
  input  wire logic                     clk_i,
  input  wire logic                     rst_i,
  input  wire vtwf_pkg::vtwf_rx_byte_t  rx_i,
  input  wire logic [15:0]              tag1_i,
  input  wire logic [15:0]              tag2_i,
  output logic                          tag1_o,
  output logic                          tag2_o,
  output logic                          over_o,
  output logic [10:0]                   cnt_o
);
  import vtwf_pkg::*;

  logic [10:0] cnt_q, cnt_d;
  logic [7:0]  hi_q, hi_d;
  logic        t1_q, t1_d, t2_q, t2_d, over_q, over_d;
  logic [10:0] pos, limit;

  // ----------------------------------------------------------------
  // Byte position, tag compare and length check
  // ----------------------------------------------------------------
  always_comb begin
    pos    = rx_i.sof ? 11'd0 : cnt_q;
    cnt_d  = cnt_q;
    hi_d   = hi_q;
    t1_d   = t1_q;
    t2_d   = t2_q;
    over_d = over_q;
    if (rx_i.valid) begin
      if (rx_i.sof) begin
        t1_d   = 1'b0;
        t2_d   = 1'b0;
        over_d = 1'b0;
      end
      if (pos == TAG_BYTE_HI) hi_d = rx_i.data;
      if (pos == TAG_BYTE_LO) begin
        t1_d = ({hi_q, rx_i.data} == tag1_i);
        t2_d = ({hi_q, rx_i.data} == tag2_i);
      end
      // Saturate so a runaway frame cannot wrap back under the limit
      if (pos != 11'h7ff) cnt_d = pos + 11'd1;
      else cnt_d = pos;
    end
    // Tagged frames get four more bytes before being judged too long
    limit = (t1_d | t2_d) ? MAX_LEN_TAGGED : MAX_LEN_PLAIN;
    if (rx_i.valid && (cnt_d > limit)) over_d = 1'b1;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q  <= 11'h000;
      hi_q   <= 8'h00;
      t1_q   <= 1'b0;
      t2_q   <= 1'b0;
      over_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      hi_q   <= hi_d;
      t1_q   <= t1_d;
      t2_q   <= t2_d;
      over_q <= over_d;
    end
  end

  assign tag1_o = t1_d;
  assign tag2_o = t2_d;
  assign over_o = over_d;
  assign cnt_o  = cnt_d;
endmodule
`default_nettype wire

/* rtl/vtwf_pattern_store.sv */
/*
  Wake pattern store: flip-flop array of DWORDs with a write port and an
  indexed read port. Assumes the caller keeps indices below the depth.
*/
`timescale 1ns/1ns
`default_nettype none
module vtwf_pattern_store #(
  parameter int DEPTH = vtwf_pkg::PATTERN_DEPTH,
  parameter int AW    = vtwf_pkg::PTR_W
) (
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  input  wire logic          we_i,
  input  wire logic [AW-1:0] waddr_i,
  input  wire logic [31:0]   wdata_i,
  input  wire logic [AW-1:0] raddr_i,
  output logic [31:0]        rdata_o
);
  import vtwf_pkg::*;

  logic [31:0] mem_q [DEPTH];
  logic [31:0] mem_d [DEPTH];

  // ----------------------------------------------------------------
  // One entry per generate step
  // ----------------------------------------------------------------
  for (genvar g = 0; g < DEPTH; g++) begin : g_ent
    always_comb begin
      mem_d[g] = mem_q[g];
      if (we_i && (waddr_i == AW'(g))) mem_d[g] = wdata_i;
    end
    always_ff @(posedge clk_i) begin
      if (rst_i) mem_q[g] <= PATTERN_RESET;
      else mem_q[g] <= mem_d[g];
    end
  end

  assign rdata_o = mem_q[raddr_i];
endmodule
`default_nettype wire

/* rtl/vtwf_top.sv */
/*
  Tag identifier registers, receive tag detection with length extension,
  and the auto-advancing wake pattern window with its pointer clear bit.
  Assumes a classic Wishbone master on clk_i and a byte stream on clk_i.
*/
// Our own choice: register access over Wishbone.
// Operation
// - Tagged frames allow 1522 bytes, else 1518
// - Compare tag fields with frame bytes 13-14
// - Checksum engine uses first tag as marker
// - First write after reset lands at entry 0
// - Each further write goes to next entry
// - Write pointer wraps after 40 entries
// - Reads return entries in sequence, advancing
// - Partial runs leave pointers where they stopped
// - Pointer clear returns both pointers to start
// - Bit 31 of wake control clears, self-clears
`timescale 1ns/1ns
`default_nettype none
module vtwf_top (
  input  wire logic                       clk_i,
  input  wire logic                       rst_i,
  // Wishbone slave
  input  wire logic                       wb_cyc_i,
  input  wire logic                       wb_stb_i,
  input  wire logic                       wb_we_i,
  input  wire logic [vtwf_pkg::ADDR_W-1:0] wb_adr_i,
  input  wire logic [3:0]                 wb_sel_i,
  input  wire logic [31:0]                wb_dat_i,
  output logic [31:0]                     wb_dat_o,
  output logic                            wb_ack_o,
  // Receive byte stream
  input  wire vtwf_pkg::vtwf_rx_byte_t    rx_i,
  // Receive results
  output vtwf_pkg::vtwf_rx_status_t       rx_status_o,
  output logic [15:0]                     rx_checksum_offload_engine_tag_o
);
  import vtwf_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [15:0]      first_tag_id_field_q, first_tag_id_field_d;
  logic [15:0]      second_tag_id_field_q, second_tag_id_field_d;
  logic [PTR_W-1:0] wr_ptr_q, wr_ptr_d;
  logic [PTR_W-1:0] rd_ptr_q, rd_ptr_d;
  logic             ack_q, ack_d;
  logic [31:0]      dat_q, dat_d;
  logic             clr_q, clr_d;
  vtwf_rx_status_t  st_q, st_d;
  logic [15:0]      coe_q;

  logic             req, wr_acc, rd_acc, store_we;
  logic [31:0]      store_rdata, sel_mask;
  logic             tag1, tag2, over;

  // Byte-enable mask for partial writes of the tag registers
  always_comb begin
    for (int b = 0; b < 4; b++) begin
      sel_mask[8*b +: 8] = {8{wb_sel_i[b]}};
    end
  end

  // New request only while no answer is pending, giving one ack per request, at most one every other clock
  assign req    = wb_cyc_i && wb_stb_i && !ack_q;
  assign wr_acc = req && wb_we_i;
  assign rd_acc = req && !wb_we_i;
  // Window writes store the whole DWORD; the pointer walk has no lanes
  assign store_we = wr_acc && (wb_adr_i == OFF_PATTERN_WIN);

  // ----------------------------------------------------------------
  // Pattern store
  // ----------------------------------------------------------------
  vtwf_pattern_store #(
    .DEPTH (PATTERN_DEPTH),
    .AW    (PTR_W)
  ) u_store (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .we_i    (store_we),
    .waddr_i (wr_ptr_q),
    .wdata_i (wb_dat_i),
    .raddr_i (rd_ptr_q),
    .rdata_o (store_rdata)
  );

  // ----------------------------------------------------------------
  // Tag detection
  // ----------------------------------------------------------------
  vtwf_tag_detect u_tag (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .rx_i   (rx_i),
    .tag1_i (first_tag_id_field_q),
    .tag2_i (second_tag_id_field_q),
    .tag1_o (tag1),
    .tag2_o (tag2),
    .over_o (over),
    .cnt_o  ()
  );

  // ----------------------------------------------------------------
  // Register file and pointers
  // ----------------------------------------------------------------
  // Tag writes land at once; changing them mid-frame is software's hazard
  always_comb begin
    first_tag_id_field_d  = first_tag_id_field_q;
    second_tag_id_field_d = second_tag_id_field_q;
    wr_ptr_d              = wr_ptr_q;
    rd_ptr_d              = rd_ptr_q;
    clr_d                 = 1'b0;
    ack_d                 = req;
    dat_d                 = 32'h0000_0000;
    if (wr_acc) begin
      case (wb_adr_i)
        OFF_FIRST_TAG: begin
          first_tag_id_field_d = (first_tag_id_field_q & ~sel_mask[15:0])
                               | (wb_dat_i[15:0] & sel_mask[15:0]);
        end
        OFF_SECOND_TAG: begin
          second_tag_id_field_d = (second_tag_id_field_q & ~sel_mask[15:0])
                                | (wb_dat_i[15:0] & sel_mask[15:0]);
        end
        OFF_PATTERN_WIN: begin
          // Wrap after the last entry so a new pass starts at filter 0
          if (wr_ptr_q == PTR_W'(PATTERN_DEPTH - 1)) wr_ptr_d = '0;
          else wr_ptr_d = wr_ptr_q + PTR_W'(1);
        end
        OFF_WAKE_CTRL: begin
          clr_d = wb_sel_i[3] && wb_dat_i[PTR_CLEAR_BIT];
        end
        default: begin
        end
      endcase
    end
    if (rd_acc) begin
      case (wb_adr_i)
        OFF_FIRST_TAG:  dat_d = {16'h0000, first_tag_id_field_q};
        OFF_SECOND_TAG: dat_d = {16'h0000, second_tag_id_field_q};
        OFF_PATTERN_WIN: begin
          dat_d = store_rdata;
          if (rd_ptr_q == PTR_W'(PATTERN_DEPTH - 1)) rd_ptr_d = '0;
          else rd_ptr_d = rd_ptr_q + PTR_W'(1);
        end
        // Clear bit always reads back as zero once it has acted
        OFF_WAKE_CTRL:  dat_d = {clr_q, 31'h0000_0000};
        default:        dat_d = UNMAPPED_READ;
      endcase
    end
    // Clear overrides any same-cycle advance; it acts on the next edge
    if (clr_q) begin
      wr_ptr_d = '0;
      rd_ptr_d = '0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      first_tag_id_field_q  <= TAG_RESET;
      second_tag_id_field_q <= TAG_RESET;
      wr_ptr_q              <= '0;
      rd_ptr_q              <= '0;
      clr_q                 <= 1'b0;
      ack_q                 <= 1'b0;
      dat_q                 <= 32'h0000_0000;
    end else begin
      first_tag_id_field_q  <= first_tag_id_field_d;
      second_tag_id_field_q <= second_tag_id_field_d;
      wr_ptr_q              <= wr_ptr_d;
      rd_ptr_q              <= rd_ptr_d;
      clr_q                 <= clr_d;
      ack_q                 <= ack_d;
      dat_q                 <= dat_d;
    end
  end

  // ----------------------------------------------------------------
  // Receive status
  // ----------------------------------------------------------------
  // Result registered on the last byte; flags held until the next frame ends, done high for one cycle only
  always_comb begin
    st_d = st_q;
    st_d.done = 1'b0;
    if (rx_i.valid && rx_i.eof) begin
      st_d.done     = 1'b1;
      st_d.tag1     = tag1;
      st_d.tag2     = tag2;
      st_d.too_long = over;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q  <= '0;
      coe_q <= TAG_RESET;
    end else begin
      st_q  <= st_d;
      coe_q <= first_tag_id_field_q;
    end
  end

  assign wb_ack_o                         = ack_q;
  assign wb_dat_o                         = dat_q;
  assign rx_status_o                      = st_q;
  assign rx_checksum_offload_engine_tag_o = coe_q;
endmodule
`default_nettype wire

/* tb/vtwf_checker.sv */
/*
  Port checker for the tag and pattern window block.
  Assumes it is bound to vtwf_top and sees only its ports.
*/
`timescale 1ns/1ns
`default_nettype none
module vtwf_checker (
  input wire logic                        clk_i,
  input wire logic                        rst_i,
  input wire logic                        wb_cyc_i,
  input wire logic                        wb_stb_i,
  input wire logic                        wb_we_i,
  input wire logic [vtwf_pkg::ADDR_W-1:0] wb_adr_i,
  input wire logic [31:0]                 wb_dat_o,
  input wire logic                        wb_ack_o,
  input wire vtwf_pkg::vtwf_rx_byte_t     rx_i,
  input wire vtwf_pkg::vtwf_rx_status_t   rx_status_o,
  input wire logic [15:0]                 rx_checksum_offload_engine_tag_o
);
  import vtwf_pkg::*;
  // ----------------------------------------------------------------
  // Bus and receive timing
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Taken requests are answered exactly one cycle later, as one pulse
  a_ack_follows: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing after request");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one");
  a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("data outside ack");
  a_done_after: assert property (rx_i.valid && rx_i.eof |=> rx_status_o.done)
    else $error("done missing after eof");
  a_done_cause: assert property (rx_status_o.done |-> $past(rx_i.valid && rx_i.eof))
    else $error("done without eof");
  // Flags only move with done; the reset guard avoids a false hit at release
  a_flags_held: assert property (!$past(rst_i) && !$stable({rx_status_o.tag1,
    rx_status_o.tag2, rx_status_o.too_long}) |-> rx_status_o.done) else $error("flags moved");
  a_coe_follows: assert property (!$past(rst_i) &&
    !$stable(rx_checksum_offload_engine_tag_o) |-> $past(wb_we_i && wb_adr_i == OFF_FIRST_TAG)
    || $past(wb_we_i && wb_adr_i == OFF_FIRST_TAG, 2)) else $error("tag copy moved alone");
endmodule
`default_nettype wire

/* tb/vlan_tag_and_wake_filter_port_bench.sv */
/*
  Self-checking bench: registers over Wishbone, tagged frames, window.
  Assumes vtwf_pkg and the design files are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none
module vlan_tag_and_wake_filter_port_bench;
  import vtwf_pkg::*;
  logic            clk_i    = 1'b0;
  logic            rst_i    = 1'b1;
  logic            wb_cyc_i = 1'b0;
  logic            wb_stb_i = 1'b0;
  logic            wb_we_i  = 1'b0;
  logic [11:0]     wb_adr_i = 12'h0;
  logic [3:0]      wb_sel_i = 4'h0;
  logic [31:0]     wb_dat_i = 32'h0;
  logic [31:0]     wb_dat_o;
  logic            wb_ack_o;
  vtwf_rx_byte_t   rx_i     = '0;
  vtwf_rx_status_t rx_status_o;
  logic [15:0]     coe_tag;
  int              err_count    = 0;
  int              total_checks = 0;
  always #5 clk_i = ~clk_i;
  vtwf_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rx_i(rx_i), .rx_status_o(rx_status_o),
    .rx_checksum_offload_engine_tag_o(coe_tag));
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
      err_count++;
    end
  endtask
  // One classic cycle; request held until ack is sampled, bounded wait
  task automatic wb(input logic we, input logic [11:0] a, input logic [31:0] d,
                    input logic [3:0] s, output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_sel_i <= s;
    wb_dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (n >= 20) begin
      err_count++;
      conclude();
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] x;
    wb(1'b1, a, d, s, x);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] x;
    wb(1'b0, a, 32'h0, 4'hf, x);
    check("read data", x, exp);
  endtask
  // Bytes 13 and 14 carry the tag; the rest are zero
  task automatic frame(input int len, input logic [15:0] tg, input logic [3:0] exp);
    for (int i = 0; i < len; i++) begin
      @(posedge clk_i);
      rx_i <= '{1'b1, i == 0, i == len - 1, i == 12 ? tg[15:8] : (i == 13 ? tg[7:0] : 8'h0)};
    end
    @(posedge clk_i);
    rx_i <= '0;
    @(posedge clk_i);
    check("rx status", {28'h0, rx_status_o}, {28'h0, exp});
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    rd(OFF_FIRST_TAG, 32'h0000_ffff);
    rd(OFF_SECOND_TAG, 32'h0000_ffff);
    rd(OFF_PATTERN_WIN, 32'h0);
    rd(OFF_WAKE_CTRL, 32'h0);
    rd(12'h200, 32'h0);
    check("coe tag", {16'h0, coe_tag}, 32'h0000_ffff);
    $display("reset test done");
  endtask
  // Upper bits stay reserved; the checksum copy follows the first tag
  task automatic t_frames();
    wr(OFF_FIRST_TAG, 32'hffff_8100, 4'h3);
    wr(OFF_SECOND_TAG, 32'hffff_88a8, 4'hf);
    rd(OFF_FIRST_TAG, 32'h0000_8100);
    rd(OFF_SECOND_TAG, 32'h0000_88a8);
    check("coe tag", {16'h0, coe_tag}, 32'h0000_8100);
    frame(1522, 16'h8100, 4'b1100);
    frame(1523, 16'h88a8, 4'b1011);
    frame(1518, 16'h0800, 4'b1000);
    frame(1519, 16'h0800, 4'b1001);
    $display("frame test done");
  endtask
  // Read pointer sits at 1 from the reset read, so reads run one entry ahead of writes
  task automatic t_window();
    int k;
    for (int i = 0; i < 40; i++) wr(OFF_PATTERN_WIN, 32'h5a00_0000 + i, 4'hf);
    wr(OFF_PATTERN_WIN, 32'hc0de_0000, 4'hf);
    for (int i = 0; i < 40; i++) begin
      k = (i + 1) % 40;
      rd(OFF_PATTERN_WIN, k == 0 ? 32'hc0de_0000 : 32'h5a00_0000 + k);
    end
    rd(OFF_PATTERN_WIN, 32'h5a00_0001);
    rd(OFF_PATTERN_WIN, 32'h5a00_0002);
    wr(OFF_WAKE_CTRL, 32'h8000_0000, 4'h8);
    rd(OFF_WAKE_CTRL, 32'h0);
    rd(OFF_PATTERN_WIN, 32'hc0de_0000);
    wr(OFF_PATTERN_WIN, 32'h1111_2222, 4'hf);
    wr(OFF_WAKE_CTRL, 32'h8000_0000, 4'h8);
    rd(OFF_PATTERN_WIN, 32'h1111_2222);
    $display("window test done");
  endtask
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_frames();
    t_window();
    conclude();
  end
endmodule
bind vtwf_top vtwf_checker chk_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .rx_i(rx_i), .rx_status_o(rx_status_o),
  .rx_checksum_offload_engine_tag_o(rx_checksum_offload_engine_tag_o));
`default_nettype wire
